// ===== inc/smcg_cfg.svh
// constants of the sleep-mode clock gating controller
`ifndef SMCG_CFG_SVH
`define SMCG_CFG_SVH

// system clock period in ns (100 MHz)
`define SMCG_CLK_PERIOD_NS 10
// least oscillator restart time after a stopped-oscillator sleep, in ns
`define SMCG_OSC_START_NS 1000
// restart time in clock cycles, rounded up
`define SMCG_OSC_START_CYC ((`SMCG_OSC_START_NS + `SMCG_CLK_PERIOD_NS - 1) / `SMCG_CLK_PERIOD_NS)
// mode selection after reset
`define SMCG_MODE_RST 3'h0
// number of flip-flops in each pin synchroniser
`define SMCG_SYNC_STAGES 2

`endif

// ===== inc/smcg_pkg.sv
// types shared by the sleep-mode clock gating controller
`default_nettype none
package smcg_pkg;

  // software-selectable sleep modes, codes 4 and 5 are reserved
  typedef enum logic [2:0] {
    SMCG_IDLE   = 3'h0,
    SMCG_ADC_NR = 3'h1,
    SMCG_PDOWN  = 3'h2,
    SMCG_PSAVE  = 3'h3,
    SMCG_STBY   = 3'h6,
    SMCG_XSTBY  = 3'h7
  } smcg_mode_t;

  // controller states
  typedef enum logic [1:0] {
    SMCG_ACTIVE = 2'h0,
    SMCG_ASLEEP = 2'h1,
    SMCG_WAKING = 2'h2
  } smcg_state_t;

  // clock enables toward the gated domains, high means clocked
  typedef struct packed {
    logic cpu;
    logic sram;
    logic timer;
    logic spi;
    logic intr;
    logic adc;
    logic async_tmr;
    logic osc;
    logic io;
  } smcg_gate_t;

  // legacy behaviour switches toward watchdog and usart
  typedef struct packed {
    logic wdt_free_change;
    logic usart_single_buf;
  } smcg_compat_t;

endpackage : smcg_pkg
`default_nettype wire

// ===== hdl/smcg_sync2.sv
// two flip-flop synchroniser for pin inputs
`default_nettype none
module smcg_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i, // system clock
  input wire logic srst_i, // synchronous reset, active high
  input wire logic [W-1:0] d_i, // asynchronous pin levels
  output logic [W-1:0] q_o // synchronised levels
);
  import smcg_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } smcg_sync_st_t;

  smcg_sync_st_t r_reg;
  smcg_sync_st_t r_next;

  // meta is read only by the second stage
  always_comb begin
    r_next = r_reg;
    r_next.meta = d_i;
    r_next.sync = r_reg.meta;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_o = r_reg.sync;
endmodule : smcg_sync2
`default_nettype wire

// ===== hdl/smcg_fuse_latch.sv
// captures the legacy compatibility fuse once after reset
`include "smcg_cfg.svh"
`default_nettype none
module smcg_fuse_latch (
  input wire logic clk_i, // system clock
  input wire logic srst_i, // synchronous reset, active high
  input wire logic fuse_sync_i, // synchronised fuse level, high = programmed
  output smcg_pkg::smcg_compat_t compat_o // legacy behaviour switches
);
  import smcg_pkg::*;

  typedef struct packed {
    logic captured;
    logic fuse;
    logic [1:0] settle;
  } smcg_fuse_st_t;

  smcg_fuse_st_t r_reg;
  smcg_fuse_st_t r_next;

  // the synchroniser is cleared by reset too, so wait until the pin level has
  // passed both flops before sampling; frozen afterwards so a glitch cannot flip it
  always_comb begin
    r_next = r_reg;
    if (!r_reg.captured) begin
      if (r_reg.settle == 2'(`SMCG_SYNC_STAGES)) begin
        r_next.fuse = fuse_sync_i; // [R09]
        r_next.captured = 1'b1;
      end else begin
        r_next.settle = r_reg.settle + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // both legacy switches follow the fuse and nothing else
  assign compat_o.wdt_free_change = r_reg.fuse; // [R10]
  assign compat_o.usart_single_buf = r_reg.fuse; // [R11]

  property p_fuse_frozen;
    @(posedge clk_i) disable iff (srst_i)
      (r_reg.captured && $past(r_reg.captured)) |-> $stable(compat_o);
  endproperty
  a_fuse_frozen: assert property (p_fuse_frozen) // [R09]
    else $error("compat switches changed after capture");

  property p_fuse_iff;
    @(posedge clk_i) disable iff (srst_i)
      $rose(r_reg.captured) |-> (compat_o.wdt_free_change == $past(fuse_sync_i))
        && (compat_o.usart_single_buf == $past(fuse_sync_i));
  endproperty
  a_fuse_iff: assert property (p_fuse_iff) // [R10]
    else $error("compat switches do not match fuse");
endmodule : smcg_fuse_latch
`default_nettype wire

// ===== hdl/smcg_ctrl.sv
// sleep mode controller: mode select, clock gating, wake-up and legacy fuse
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R01: six sleep modes, each selectable by software
// R02: idle stops cpu only, rest keeps running
// R03: power-down stops oscillator and all functions
// R04: interrupt or reset restarts oscillator, ends sleep
// R05: power-save keeps asynchronous timer counting
// R06: adc noise mode keeps only adc, async timer; the code also keeps osc clocked
// R07: standby keeps oscillator running, rest gated
// R08: extended standby keeps oscillator and async timer
// R09: legacy behaviour enabled exactly when fuse programmed
// R10: fuse lets watchdog period change without unlock
// R11: fuse makes usart receive single buffered
// R12: sleep needs prior mode write, wake restores all
//////////////////////////////////////////////////////////////////////////////
`include "smcg_cfg.svh"
`default_nettype none
module smcg_ctrl #(
  parameter int START_CYCLES = `SMCG_OSC_START_CYC // oscillator restart wait
) (
  input wire logic clk_i, // system clock, 100 MHz
  input wire logic srst_i, // hardware reset, synchronous, active high
  input wire logic [2:0] mode_sel_i, // mode code written by the cpu
  input wire logic mode_wr_i, // one-cycle strobe, takes mode_sel_i
  input wire logic sleep_req_i, // one-cycle strobe, sleep instruction
  input wire logic irq_i, // pending interrupt from interrupt logic
  input wire logic ext_wake_i, // external interrupt pin, asynchronous
  input wire logic legacy_compat_fuse_i, // fuse level, high = programmed
  output smcg_pkg::smcg_gate_t gate_o, // clock enables per domain
  output smcg_pkg::smcg_mode_t mode_o, // selected mode
  output logic armed_o, // a legal mode has been written
  output logic sleeping_o, // device is asleep
  output logic waking_o, // oscillator restart in progress
  output logic wake_o, // one-cycle pulse on return to active
  output smcg_pkg::smcg_compat_t compat_o // legacy behaviour switches
);
  import smcg_pkg::*;

  localparam int CW = $clog2(START_CYCLES + 1);
  localparam int WAKE_SPAN = START_CYCLES + 1;

  typedef struct packed {
    smcg_state_t state;
    smcg_mode_t mode;
    logic armed;
    logic [CW-1:0] cnt;
    smcg_gate_t gate;
    logic wake;
  } smcg_ctrl_st_t;

  smcg_ctrl_st_t r_reg;
  smcg_ctrl_st_t r_next;
  logic [1:0] pins_sync;
  logic wake_ev;
  logic mode_legal;

  //////////////////////////////////////////////////////////////////////////
  // pin inputs: wake pin and fuse both cross in through two flops
  smcg_sync2 #(
    .W(2) // two pins: fuse and wake
  ) u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i({legacy_compat_fuse_i, ext_wake_i}),
    .q_o(pins_sync)
  );

  // fuse is sampled once, later changes take effect only after a reset
  smcg_fuse_latch u_fuse (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .fuse_sync_i(pins_sync[1]),
    .compat_o(compat_o)
  );

  //////////////////////////////////////////////////////////////////////////
  // gate table per sleep mode; every mode keeps interrupt wake-up possible
  // through the always-on wake path, not through the gated interrupt clock
  function automatic smcg_gate_t smcg_sleep_gates(input smcg_mode_t m);
    smcg_gate_t g;
    g = '0;
    unique case (m)
      SMCG_IDLE: begin
        g = '1; // [R02]
        g.cpu = 1'b0;
      end
      SMCG_ADC_NR: begin
        g.adc = 1'b1; // [R06]
        g.async_tmr = 1'b1;
        g.osc = 1'b1;
      end
      SMCG_PDOWN: begin
        g = '0; // [R03]
      end
      SMCG_PSAVE: begin
        g.async_tmr = 1'b1; // [R05]
      end
      SMCG_STBY: begin
        g.osc = 1'b1; // [R07]
      end
      SMCG_XSTBY: begin
        g.osc = 1'b1; // [R08]
        g.async_tmr = 1'b1;
      end
    endcase
    return g;
  endfunction : smcg_sleep_gates

  // reserved codes are dropped so a stray write cannot pick a bad mode
  always_comb begin
    unique case (mode_sel_i)
      3'h4, 3'h5: mode_legal = 1'b0;
      default: mode_legal = 1'b1; // [R01]
    endcase
  end

  // interrupt from logic or from the pin wakes the device
  assign wake_ev = irq_i | pins_sync[0]; // [R04]

  //////////////////////////////////////////////////////////////////////////
  // next state: register contents are held across sleep, nothing is cleared
  always_comb begin
    r_next = r_reg;
    r_next.wake = 1'b0;
    unique case (r_reg.state)
      SMCG_ACTIVE: begin
        if (mode_wr_i && mode_legal) begin
          r_next.mode = smcg_mode_t'(mode_sel_i); // [R01]
          r_next.armed = 1'b1;
        end
        // uses the mode held before this cycle, a same-cycle write waits
        if (sleep_req_i && r_reg.armed) begin
          r_next.state = SMCG_ASLEEP; // [R12]
          r_next.gate = smcg_sleep_gates(r_reg.mode);
        end
      end
      SMCG_ASLEEP: begin
        if (wake_ev) begin
          if (!r_reg.gate.osc) begin
            // oscillator was stopped, let it settle before the cpu runs
            r_next.state = SMCG_WAKING; // [R04]
            r_next.cnt = CW'(START_CYCLES - 1);
            r_next.gate = '0;
            r_next.gate.osc = 1'b1;
          end else begin
            // oscillator kept running, so the cpu restarts at once
            r_next.state = SMCG_ACTIVE; // [R07]
            r_next.gate = '1;
            r_next.wake = 1'b1;
          end
        end
      end
      SMCG_WAKING: begin
        if (r_reg.cnt == '0) begin
          r_next.state = SMCG_ACTIVE; // [R12]
          r_next.gate = '1;
          r_next.wake = 1'b1;
        end else begin
          r_next.cnt = r_reg.cnt - CW'(1);
        end
      end
      default: begin
        r_next.state = SMCG_ACTIVE;
        r_next.gate = '1;
      end
    endcase
  end

  // hardware reset returns to active with every domain clocked
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r_reg.state <= SMCG_ACTIVE; // [R04]
      r_reg.mode <= smcg_mode_t'(`SMCG_MODE_RST);
      r_reg.armed <= 1'b0;
      r_reg.cnt <= '0;
      r_reg.gate <= '1;
      r_reg.wake <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state flops
  assign gate_o = r_reg.gate;
  assign mode_o = r_reg.mode;
  assign armed_o = r_reg.armed;
  assign sleeping_o = (r_reg.state == SMCG_ASLEEP);
  assign waking_o = (r_reg.state == SMCG_WAKING);
  assign wake_o = r_reg.wake;

  //////////////////////////////////////////////////////////////////////////
  // checks on the gating table and the sleep sequence
  property p_reserved_ignored;
    @(posedge clk_i) disable iff (srst_i)
      (mode_wr_i && (mode_sel_i[2:1] == 2'b10)) |=> (mode_o == $past(mode_o));
  endproperty
  a_reserved_ignored: assert property (p_reserved_ignored) // [R01]
    else $error("reserved mode code was accepted");

  property p_idle_gates;
    @(posedge clk_i) disable iff (srst_i)
      (sleeping_o && mode_o == SMCG_IDLE) |-> (!gate_o.cpu && gate_o.sram
        && gate_o.timer && gate_o.spi && gate_o.intr && gate_o.osc);
  endproperty
  a_idle_gates: assert property (p_idle_gates) // [R02]
    else $error("idle gating wrong");

  property p_pdown_gates;
    @(posedge clk_i) disable iff (srst_i)
      (sleeping_o && mode_o == SMCG_PDOWN) |-> (gate_o == '0);
  endproperty
  a_pdown_gates: assert property (p_pdown_gates) // [R03]
    else $error("power-down left a domain clocked");

  property p_pdown_wake;
    @(posedge clk_i) disable iff (srst_i)
      (sleeping_o && !gate_o.osc && wake_ev) |=> (gate_o.osc && !gate_o.cpu)
        ##[1:WAKE_SPAN] (gate_o == '1) && wake_o;
  endproperty
  a_pdown_wake: assert property (p_pdown_wake) // [R04]
    else $error("no restart after wake from stopped oscillator");

  property p_psave_gates;
    @(posedge clk_i) disable iff (srst_i)
      (sleeping_o && mode_o == SMCG_PSAVE) |-> (gate_o.async_tmr
        && !gate_o.osc && !gate_o.cpu && !gate_o.sram);
  endproperty
  a_psave_gates: assert property (p_psave_gates) // [R05]
    else $error("power-save gating wrong");

  property p_adc_gates;
    @(posedge clk_i) disable iff (srst_i)
      (sleeping_o && mode_o == SMCG_ADC_NR) |-> (gate_o.adc && gate_o.async_tmr
        && !gate_o.cpu && !gate_o.io && !gate_o.spi && !gate_o.timer);
  endproperty
  a_adc_gates: assert property (p_adc_gates) // [R06]
    else $error("adc noise reduction gating wrong");

  property p_stby_fast;
    @(posedge clk_i) disable iff (srst_i)
      (sleeping_o && mode_o == SMCG_STBY) |-> (gate_o.osc && !gate_o.async_tmr
        && !gate_o.cpu) and (wake_ev |=> (wake_o && gate_o.cpu));
  endproperty
  a_stby_fast: assert property (p_stby_fast) // [R07]
    else $error("standby gating or fast wake wrong");

  property p_xstby_gates;
    @(posedge clk_i) disable iff (srst_i)
      (sleeping_o && mode_o == SMCG_XSTBY) |-> (gate_o.osc && gate_o.async_tmr
        && !gate_o.cpu && !gate_o.adc);
  endproperty
  a_xstby_gates: assert property (p_xstby_gates) // [R08]
    else $error("extended standby gating wrong");

  // oscillator kept running, so the return needs no restart wait
  property p_xstby_fast;
    @(posedge clk_i) disable iff (srst_i)
      (sleeping_o && mode_o == SMCG_XSTBY && wake_ev) |=> wake_o && (gate_o == '1);
  endproperty
  a_xstby_fast: assert property (p_xstby_fast) // [R08]
    else $error("extended standby wake was not immediate");

  // sleep only ends on an interrupt; reset is masked by the disable clause
  property p_wake_needs_event;
    @(posedge clk_i) disable iff (srst_i)
      $fell(sleeping_o) |-> $past(wake_ev);
  endproperty
  a_wake_needs_event: assert property (p_wake_needs_event) // [R04]
    else $error("sleep ended without a wake event");

  // during the restart wait only the oscillator runs
  property p_waking_gates;
    @(posedge clk_i) disable iff (srst_i)
      waking_o |-> (gate_o.osc && !gate_o.cpu && !gate_o.sram && !gate_o.io);
  endproperty
  a_waking_gates: assert property (p_waking_gates) // [R04]
    else $error("domain clocked during oscillator restart");

  // selected mode and arming survive sleep and restart untouched
  property p_mode_kept;
    @(posedge clk_i) disable iff (srst_i)
      (sleeping_o || waking_o) |=> (mode_o == $past(mode_o)) && armed_o;
  endproperty
  a_mode_kept: assert property (p_mode_kept) // [R03]
    else $error("register contents lost in sleep");

  property p_entry_armed;
    @(posedge clk_i) disable iff (srst_i)
      $rose(sleeping_o) |-> ($past(sleep_req_i) && $past(armed_o)
        && !gate_o.cpu);
  endproperty
  a_entry_armed: assert property (p_entry_armed) // [R12]
    else $error("sleep entered without mode and request");

  property p_no_arm_no_sleep;
    @(posedge clk_i) disable iff (srst_i)
      (!armed_o && !sleeping_o) |=> !sleeping_o;
  endproperty
  a_no_arm_no_sleep: assert property (p_no_arm_no_sleep) // [R12]
    else $error("sleep before any mode write");

  property p_wake_full;
    @(posedge clk_i) disable iff (srst_i)
      wake_o |-> (gate_o == '1) && !sleeping_o && !waking_o;
  endproperty
  a_wake_full: assert property (p_wake_full) // [R12]
    else $error("wake did not restore full operation");
endmodule : smcg_ctrl
`default_nettype wire

// ===== tb/smcg_irq_model.sv
// partner model: interrupt source beside the sleep controller
`default_nettype none
module smcg_irq_model (
  input wire logic clk_i, // system clock
  input wire logic srst_i, // synchronous reset, active high
  input wire logic sleeping_i, // controller reports sleep
  input wire logic wake_i, // return-to-active pulse
  input wire logic [7:0] delay_i, // cycles asleep before the interrupt
  input wire logic kick_i, // bench-ordered interrupt at any time
  output logic irq_o // pending interrupt level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg;
  logic pend_reg;
  ////////////////////////////////////////////////////////////////////////////
  // pending stays up through the restart wait, as a real source would
  always_ff @(posedge clk_i) begin
    if (srst_i || wake_i) begin
      cnt_reg <= 8'h00;
      pend_reg <= 1'b0;
    end else if (sleeping_i && !pend_reg) begin
      cnt_reg <= cnt_reg + 8'h01;
      if (cnt_reg == delay_i) pend_reg <= 1'b1;
    end
  end
  assign irq_o = pend_reg | kick_i; // kick lets the bench try a wake while active
endmodule : smcg_irq_model
`default_nettype wire

// ===== tb/tb_smcg_ctrl.sv
// self-checking bench of the sleep-mode clock gating controller
`default_nettype none
module tb_smcg_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import smcg_pkg::*;
  localparam int START = 4; // shortened oscillator restart wait
  logic clk_i, srst_i, mode_wr_i, sleep_req_i, irq_i, ext_wake_i, fuse_i, kick;
  logic [2:0] mode_sel_i;
  logic [7:0] delay, rnd;
  smcg_gate_t gate_o;
  smcg_mode_t mode_o;
  smcg_compat_t compat_o;
  logic armed_o, sleeping_o, waking_o, wake_o;
  int err_total, checks, cyc, n;
  smcg_mode_t m;
  smcg_mode_t codes [6] = '{SMCG_IDLE, SMCG_ADC_NR, SMCG_PDOWN, SMCG_PSAVE, SMCG_STBY, SMCG_XSTBY};
  ////////////////////////////////////////////////////////////////////////////
  smcg_ctrl #(.START_CYCLES(START)) i_dut (
    .clk_i(clk_i), .srst_i(srst_i), .mode_sel_i(mode_sel_i), .mode_wr_i(mode_wr_i),
    .sleep_req_i(sleep_req_i), .irq_i(irq_i), .ext_wake_i(ext_wake_i),
    .legacy_compat_fuse_i(fuse_i), .gate_o(gate_o), .mode_o(mode_o), .armed_o(armed_o),
    .sleeping_o(sleeping_o), .waking_o(waking_o), .wake_o(wake_o), .compat_o(compat_o)
  );
  smcg_irq_model i_irq (
    .clk_i(clk_i), .srst_i(srst_i), .sleeping_i(sleeping_o), .wake_i(wake_o),
    .delay_i(delay), .kick_i(kick), .irq_o(irq_i)
  );
  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // inputs change 1 ns after the edge, so outputs are settled when read
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  // clocked domains per mode, {cpu,sram,timer,spi,intr,adc,async,osc,io}
  function automatic logic [8:0] gate_exp(input logic [2:0] c);
    case (c)
      3'h0: return 9'h0FF;
      3'h1: return 9'h00E;
      3'h3: return 9'h004;
      3'h6: return 9'h002;
      3'h7: return 9'h006;
      default: return 9'h000;
    endcase
  endfunction : gate_exp
  task automatic do_reset();
    srst_i = 1'b1;
    repeat (3) tick();
    srst_i = 1'b0;
  endtask : do_reset
  task automatic write_mode(input logic [2:0] c);
    mode_sel_i = c;
    mode_wr_i = 1'b1;
    tick();
    mode_wr_i = 1'b0;
  endtask : write_mode
  task automatic test_done();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {srst_i, mode_wr_i, sleep_req_i, ext_wake_i, fuse_i, kick} = 6'h00;
    mode_sel_i = 3'h0;
    delay = 8'h00;
    rnd = 8'h14;
    do_reset();
    chk({gate_o, mode_o, armed_o, sleeping_o, waking_o, wake_o}, 16'hFF80);
    sleep_req_i = 1'b1;
    tick();
    sleep_req_i = 1'b0;
    chk({15'h0, sleeping_o}, 16'h0);
    // two reserved codes back to back, strobe held high across both
    mode_sel_i = 3'h4;
    mode_wr_i = 1'b1;
    tick();
    mode_sel_i = 3'h5;
    tick();
    mode_wr_i = 1'b0;
    chk({12'h0, mode_o, armed_o}, 16'h0);
    kick = 1'b1;
    repeat (2) tick();
    kick = 1'b0;
    chk({5'h0, sleeping_o, wake_o, gate_o}, 16'h01FF);
    // every mode twice: interrupt wake first, pin wake second
    for (int i = 0; i < 12; i++) begin
      m = codes[i % 6];
      rnd = lfsr(rnd);
      delay = (i < 6) ? {4'h0, rnd[3:0]} : 8'hFF;
      write_mode(m);
      chk({12'h0, mode_o, armed_o}, {12'h0, m, 1'b1});
      sleep_req_i = 1'b1;
      tick();
      sleep_req_i = 1'b0;
      chk({6'h0, sleeping_o, gate_o}, {6'h0, 1'b1, gate_exp(m)});
      mode_sel_i = rnd[2:0];
      mode_wr_i = 1'b1;
      tick();
      mode_wr_i = 1'b0;
      chk({3'h0, sleeping_o, gate_o, mode_o}, {3'h0, 1'b1, gate_exp(m), m});
      if (i >= 6) begin
        repeat (rnd[2:0]) tick();
        ext_wake_i = 1'b1;
      end
      n = 0;
      while (sleeping_o === 1'b1 && n < 300) begin
        tick();
        n++;
      end
      if (gate_exp(m) & 9'h002) begin
        chk({5'h0, waking_o, wake_o, gate_o}, 16'h03FF);
      end else begin
        chk({5'h0, waking_o, wake_o, gate_o}, 16'h0402);
        n = 0;
        while (wake_o !== 1'b1 && n < 50) begin
          tick();
          n++;
        end
        chk(n[15:0], START[15:0]);
        chk({7'h0, gate_o}, 16'h01FF);
      end
      chk({12'h0, mode_o, armed_o}, {12'h0, m, 1'b1});
      ext_wake_i = 1'b0;
      tick();
      chk({15'h0, wake_o}, 16'h0);
      repeat (2) tick();
    end
    // hardware reset ends a power-down sleep
    write_mode(3'h2);
    sleep_req_i = 1'b1;
    tick();
    sleep_req_i = 1'b0;
    chk({15'h0, sleeping_o}, 16'h1);
    do_reset();
    chk({gate_o, mode_o, armed_o, sleeping_o, waking_o, wake_o}, 16'hFF80);
    // legacy switches follow the fuse, sampled again after each reset
    fuse_i = 1'b1;
    do_reset();
    repeat (3) tick();
    chk({15'h0, compat_o.wdt_free_change}, 16'h1);
    chk({15'h0, compat_o.usart_single_buf}, 16'h1);
    fuse_i = 1'b0;
    do_reset();
    repeat (3) tick();
    chk({14'h0, compat_o}, 16'h0);
    test_done();
  end
endmodule : tb_smcg_ctrl
`default_nettype wire
